// [oscsd_sequencer.sv]
// oscsd_sequencer: oscillator start-up and reset delay sequencer
module oscsd_sequencer
   import oscsd_pkg::*;
#(
   parameter int CNT_W = CNT_W_DEF,
   parameter int XTAL_WAKE_CYC = WAKE_16K_CYC,
   parameter int LF_WAKE_CYC = WAKE_32K_CYC,
   parameter int RESET_SHORT_DLY = RESET_SHORT_CYC,
   parameter int RESET_LONG_DLY = RESET_LONG_CYC
)
(
   input wire logic core_clk, // selected oscillator clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic [3:0] clock_source_select, // non-volatile source selection
   input wire logic [1:0] startup_time_select, // non-volatile start-up selection
   input wire logic ext_reset_n, // hardware reset pin, active low
   input wire logic power_on_reset, // power-on reset, active high
   input wire logic brownout_detector, // brown-out reset, active high
   input wire logic wake_irq, // wake interrupt, active high level
   input wire logic sleep_req, // one-cycle sleep request from core
   input wire logic [1:0] sleep_mode, // sleep mode with the request
   output logic osc_enable, // oscillator running
   output logic lf_osc_select, // low-frequency crystal selected
   output logic async_timer_enable, // asynchronous timer running
   output logic core_clk_enable, // internal clock released
   output logic core_reset, // internal reset held, active high
   output logic state_retain, // register contents held in sleep
   output logic startup_busy // start-up or reset delay counting
);

   if (CNT_W < 2 || CNT_W > 30)
   begin : g_chk_w
      $error("oscsd_sequencer: CNT_W out of range");
   end
   if (RESET_LONG_DLY >= (1 << CNT_W) || RESET_SHORT_DLY >= (1 << CNT_W)
       || LF_WAKE_CYC >= (1 << CNT_W) || XTAL_WAKE_CYC >= (1 << CNT_W))
   begin : g_chk_fit
      $error("oscsd_sequencer: a delay does not fit CNT_W");
   end
   if (RESET_SHORT_DLY < 1 || RESET_LONG_DLY < 1 || XTAL_WAKE_CYC < 1 || LF_WAKE_CYC < 1)
   begin : g_chk_min
      $error("oscsd_sequencer: delays must be at least one cycle");
   end

   typedef enum logic [2:0] {
      ST_HOLD,
      ST_OSC_COUNT,
      ST_EXTRA,
      ST_RUN,
      ST_SLEEP
   } oscsd_state_e;

   // ------------------------------------------------------------
   // input synchronisation
   // ------------------------------------------------------------
   logic [LN_COUNT-1:0] pin_raw;
   logic [LN_COUNT-1:0] pin_sync;
   logic any_reset;
   logic wake_seen;

   assign pin_raw[LN_EXT_RST] = ~ext_reset_n;
   assign pin_raw[LN_POR] = power_on_reset;
   assign pin_raw[LN_BOD] = brownout_detector;
   assign pin_raw[LN_WAKE] = wake_irq;

   oscsd_sync #(
      .WIDTH(LN_COUNT)
   ) u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .rst_val('0),
      .async_in(pin_raw),
      .sync_out(pin_sync)
   );

   assign any_reset = pin_sync[LN_EXT_RST] | pin_sync[LN_POR] | pin_sync[LN_BOD];
   assign wake_seen = pin_sync[LN_WAKE];

   // ------------------------------------------------------------
   // count mapping
   // ------------------------------------------------------------
   function automatic logic [CNT_W-1:0] wake_load(input oscsd_wake_e w);
      logic [CNT_W-1:0] r;
      r = CNT_W'(WAKE_1K_CYC - 1);
      unique case (w)
         WK_258: r = CNT_W'(WAKE_258_CYC - 1);
         WK_1K: r = CNT_W'(WAKE_1K_CYC - 1);
         WK_16K: r = CNT_W'(XTAL_WAKE_CYC - 1);
         WK_32K: r = CNT_W'(LF_WAKE_CYC - 1);
      endcase
      return r;
   endfunction

   function automatic logic [CNT_W-1:0] extra_load(input oscsd_extra_e e);
      logic [CNT_W-1:0] r;
      r = '0;
      unique case (e)
         EX_NONE: r = '0;
         EX_SHORT: r = CNT_W'(RESET_SHORT_DLY - 1);
         EX_LONG: r = CNT_W'(RESET_LONG_DLY - 1);
         default: r = '0;
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------
   // selection capture, tracked only while reset is held
   // ------------------------------------------------------------
   oscsd_start_s sel;
   oscsd_start_s next_sel;
   logic lf_sel;
   logic next_lf_sel;

   oscsd_state_e state;
   oscsd_state_e next_state;

   always_comb
   begin
      next_sel = sel;
      next_lf_sel = lf_sel;
      if (state == ST_HOLD)
      begin
         next_sel = decode_startup(clock_source_select, startup_time_select);
         next_lf_sel = (clock_source_select == SRC_LF_CRYSTAL);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         sel <= '{WK_1K, EX_LONG};
         lf_sel <= 1'b0;
      end
      else
      begin
         sel <= next_sel;
         lf_sel <= next_lf_sel;
      end
   end

   // ------------------------------------------------------------
   // sequencer state and delay counter
   // ------------------------------------------------------------
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic from_reset;
   logic next_from_reset;
   logic [1:0] slp_mode;
   logic [1:0] next_slp_mode;

   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      next_from_reset = from_reset;
      next_slp_mode = slp_mode;
      if (any_reset)
      begin
         next_state = ST_HOLD;
         next_from_reset = 1'b1;
         next_cnt = '0;
      end
      else
      begin
         unique case (state)
            ST_HOLD:
            begin
               next_state = ST_OSC_COUNT;
               next_cnt = wake_load(next_sel.wake);
               next_from_reset = 1'b1;
            end
            ST_OSC_COUNT:
            begin
               if (cnt != '0)
               begin
                  next_cnt = cnt - CNT_W'(1);
               end
               else if (from_reset && sel.extra != EX_NONE)
               begin
                  next_state = ST_EXTRA;
                  next_cnt = extra_load(sel.extra);
               end
               else
               begin
                  next_state = ST_RUN;
               end
            end
            ST_EXTRA:
            begin
               if (cnt != '0)
               begin
                  next_cnt = cnt - CNT_W'(1);
               end
               else
               begin
                  next_state = ST_RUN;
                  next_from_reset = 1'b0;
               end
            end
            ST_RUN:
            begin
               next_from_reset = 1'b0;
               if (sleep_req)
               begin
                  next_state = ST_SLEEP;
                  next_slp_mode = sleep_mode;
               end
            end
            ST_SLEEP:
            begin
               if (wake_seen)
               begin
                  next_state = ST_OSC_COUNT;
                  next_from_reset = 1'b0;
                  if (slp_mode == SLP_STANDBY)
                  begin
                     next_cnt = CNT_W'(STANDBY_WAKE_CYC - 1);
                  end
                  else
                  begin
                     next_cnt = wake_load(sel.wake);
                  end
               end
            end
            default:
            begin
               next_state = ST_HOLD;
               next_from_reset = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state <= ST_HOLD;
         cnt <= '0;
         from_reset <= 1'b1;
         slp_mode <= SLP_POWER_DOWN;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         from_reset <= next_from_reset;
         slp_mode <= next_slp_mode;
      end
   end

   // ------------------------------------------------------------
   // registered outputs from the next state
   // ------------------------------------------------------------
   logic next_osc_enable;
   logic next_async_timer_enable;
   logic next_core_clk_enable;
   logic next_core_reset;
   logic next_state_retain;
   logic next_startup_busy;

   always_comb
   begin
      next_osc_enable = 1'b1;
      next_async_timer_enable = 1'b0;
      next_core_clk_enable = 1'b0;
      next_core_reset = 1'b1;
      next_state_retain = 1'b0;
      next_startup_busy = 1'b0;
      unique case (next_state)
         ST_HOLD:
         begin
            next_core_reset = 1'b1;
         end
         ST_OSC_COUNT, ST_EXTRA:
         begin
            next_startup_busy = 1'b1;
            next_core_reset = next_from_reset;
            next_state_retain = ~next_from_reset;
         end
         ST_RUN:
         begin
            next_core_reset = 1'b0;
            next_core_clk_enable = 1'b1;
            next_async_timer_enable = 1'b1;
         end
         ST_SLEEP:
         begin
            next_core_reset = 1'b0;
            next_state_retain = 1'b1;
            next_osc_enable = (next_slp_mode == SLP_STANDBY);
            next_async_timer_enable = (next_slp_mode == SLP_POWER_SAVE);
         end
         default:
         begin
            next_core_reset = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         osc_enable <= 1'b1;
         lf_osc_select <= 1'b0;
         async_timer_enable <= 1'b0;
         core_clk_enable <= 1'b0;
         core_reset <= 1'b1;
         state_retain <= 1'b0;
         startup_busy <= 1'b0;
      end
      else
      begin
         osc_enable <= next_osc_enable;
         lf_osc_select <= next_lf_sel;
         async_timer_enable <= next_async_timer_enable;
         core_clk_enable <= next_core_clk_enable;
         core_reset <= next_core_reset;
         state_retain <= next_state_retain;
         startup_busy <= next_startup_busy;
      end
   end

endmodule

// [oscsd_pkg.sv]
// oscsd_pkg: constants, types and selection decode for the start-up sequencer
package oscsd_pkg;

   // ------------------------------------------------------------
   // clock and time base
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 10000;
   localparam int RESET_SHORT_NS = 4100000;
   localparam int RESET_LONG_NS = 65000000;
   localparam int CLK_PERIOD_NS = CLK_PERIOD_PS / 1000;
   // least times, rounded up to whole cycles; kept in ns so int cannot overflow
   localparam int RESET_SHORT_CYC = (RESET_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_LONG_CYC = (RESET_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // oscillator start-up counts and default counter width
   // ------------------------------------------------------------
   localparam int WAKE_258_CYC = 258;
   localparam int WAKE_1K_CYC = 1024;
   localparam int WAKE_16K_CYC = 16384;
   localparam int WAKE_32K_CYC = 32768;
   localparam int STANDBY_WAKE_CYC = 6;
   localparam int CNT_W_DEF = 24;

   // ------------------------------------------------------------
   // selection codes
   // ------------------------------------------------------------
   localparam logic [3:0] SRC_LF_CRYSTAL = 4'h9;
   localparam logic [3:0] SRC_CRYSTAL_LO = 4'hA;
   localparam int SRC_LOW_BIT = 0;
   localparam logic [1:0] SUT_00 = 2'h0;
   localparam logic [1:0] SUT_01 = 2'h1;
   localparam logic [1:0] SUT_10 = 2'h2;
   localparam logic [1:0] SUT_11 = 2'h3;

   // sleep mode encoding on the sleep request port
   localparam logic [1:0] SLP_POWER_DOWN = 2'h0;
   localparam logic [1:0] SLP_POWER_SAVE = 2'h1;
   localparam logic [1:0] SLP_STANDBY = 2'h2;

   // synchroniser lane order
   localparam int LN_EXT_RST = 0;
   localparam int LN_POR = 1;
   localparam int LN_BOD = 2;
   localparam int LN_WAKE = 3;
   localparam int LN_COUNT = 4;

   typedef enum logic [1:0] {WK_258, WK_1K, WK_16K, WK_32K} oscsd_wake_e;
   typedef enum logic [1:0] {EX_NONE, EX_SHORT, EX_LONG} oscsd_extra_e;

   typedef struct packed {
      oscsd_wake_e wake;
      oscsd_extra_e extra;
   } oscsd_start_s;

   // maps source and start-up selection to wake count and reset delay
   function automatic oscsd_start_s decode_startup(input logic [3:0] src,
                                                  input logic [1:0] sut);
      oscsd_start_s r;
      r.wake = WK_1K;
      r.extra = EX_LONG;
      if (src == SRC_LF_CRYSTAL)
      begin
         unique case (sut)
            SUT_00: r = '{WK_1K, EX_SHORT};
            SUT_01: r = '{WK_1K, EX_LONG};
            default: r = '{WK_32K, EX_LONG};
         endcase
      end
      else if (src >= SRC_CRYSTAL_LO)
      begin
         unique case ({src[SRC_LOW_BIT], sut})
            {1'b0, SUT_00}: r = '{WK_258, EX_SHORT};
            {1'b0, SUT_01}: r = '{WK_258, EX_LONG};
            {1'b0, SUT_10}: r = '{WK_1K, EX_NONE};
            {1'b0, SUT_11}: r = '{WK_1K, EX_SHORT};
            {1'b1, SUT_00}: r = '{WK_1K, EX_LONG};
            {1'b1, SUT_01}: r = '{WK_16K, EX_NONE};
            {1'b1, SUT_10}: r = '{WK_16K, EX_SHORT};
            {1'b1, SUT_11}: r = '{WK_16K, EX_LONG};
         endcase
      end
      return r;
   endfunction

endpackage

// [oscsd_sync.sv]
// oscsd_sync: three-stage synchroniser that accepts a change once stages agree
module oscsd_sync
   import oscsd_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   input wire logic core_clk, // block clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic [WIDTH-1:0] rst_val, // value shown while in reset
   input wire logic [WIDTH-1:0] async_in, // levels from outside the domain
   output logic [WIDTH-1:0] sync_out // accepted levels
);

   if (WIDTH < 1)
   begin : g_chk
      $error("oscsd_sync: WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_sync_out;

   // ------------------------------------------------------------
   // accept per bit when second and third stage agree
   // ------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < WIDTH; i++)
      begin
         next_sync_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         stage1 <= rst_val;
         stage2 <= rst_val;
         stage3 <= rst_val;
         sync_out <= rst_val;
      end
      else
      begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         sync_out <= next_sync_out;
      end
   end

endmodule

// [oscsd_monitor.sv]
// oscsd_monitor: port-level assertions for the start-up sequencer
module oscsd_monitor
   import oscsd_pkg::*;
(
   input wire logic core_clk, // clock
   input wire logic sys_rst, // synchronous reset
   input wire logic [3:0] clock_source_select, // source selection
   input wire logic [1:0] startup_time_select, // start-up selection
   input wire logic ext_reset_n, // reset pin
   input wire logic power_on_reset, // power-on reset
   input wire logic brownout_detector, // brown-out reset
   input wire logic wake_irq, // wake interrupt
   input wire logic sleep_req, // sleep request
   input wire logic [1:0] sleep_mode, // sleep mode
   input wire logic osc_enable, // oscillator running
   input wire logic lf_osc_select, // low-frequency source
   input wire logic async_timer_enable, // async timer running
   input wire logic core_clk_enable, // clock released
   input wire logic core_reset, // internal reset
   input wire logic state_retain, // state held
   input wire logic startup_busy // counting
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking mon_cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   AST_RUN_CLEAN: assert property (core_clk_enable |-> !core_reset && !startup_busy)
      else $error("clock released while reset or count active");
   AST_BUSY_OSC: assert property (startup_busy |-> !core_clk_enable && osc_enable)
      else $error("count active without running oscillator or with clock");
   AST_CE_RISE: assert property ($rose(core_clk_enable) |-> $past(startup_busy))
      else $error("clock released without a count");
   AST_PDOWN: assert property (core_clk_enable && sleep_req && sleep_mode == SLP_POWER_DOWN
      |=> !osc_enable && !async_timer_enable && state_retain && !core_clk_enable)
      else $error("power-down entry wrong");
   AST_PSAVE: assert property (core_clk_enable && sleep_req && sleep_mode == SLP_POWER_SAVE
      |=> async_timer_enable && !osc_enable && state_retain)
      else $error("power-save entry wrong");
   AST_STANDBY: assert property (core_clk_enable && sleep_req && sleep_mode == SLP_STANDBY
      |=> osc_enable && !async_timer_enable && state_retain)
      else $error("standby entry wrong");
   AST_LF_SEL: assert property ($rose(startup_busy) && core_reset
      |-> lf_osc_select == ($past(clock_source_select) == SRC_LF_CRYSTAL))
      else $error("low-frequency select wrong");
   AST_RETAIN_NO_RST: assert property (state_retain |-> !core_reset)
      else $error("reset while state held");
endmodule

bind oscsd_sequencer oscsd_monitor u_mon (
   .core_clk(core_clk),
   .sys_rst(sys_rst),
   .clock_source_select(clock_source_select),
   .startup_time_select(startup_time_select),
   .ext_reset_n(ext_reset_n),
   .power_on_reset(power_on_reset),
   .brownout_detector(brownout_detector),
   .wake_irq(wake_irq),
   .sleep_req(sleep_req),
   .sleep_mode(sleep_mode),
   .osc_enable(osc_enable),
   .lf_osc_select(lf_osc_select),
   .async_timer_enable(async_timer_enable),
   .core_clk_enable(core_clk_enable),
   .core_reset(core_reset),
   .state_retain(state_retain),
   .startup_busy(startup_busy)
);

// [oscsd_xtal_model.sv]
// oscsd_xtal_model: external crystal, ticks only while enabled
module oscsd_xtal_model
(
   input wire logic core_clk, // reference clock
   input wire logic osc_enable, // enable from sequencer
   output logic [31:0] osc_ticks // oscillator cycles produced
);
   timeunit 1ns;
   timeprecision 1ps;
   initial osc_ticks = 32'h0000_0000;
   // frozen while stopped
   always @(posedge core_clk)
   begin
      if (osc_enable)
         osc_ticks <= osc_ticks + 32'h0000_0001;
   end
endmodule

// [oscsd_sequencer_tb.sv]
// oscsd_sequencer_tb: self-checking bench for the start-up sequencer
module oscsd_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import oscsd_pkg::*;
   localparam int XW = 40;
   localparam int LW = 50;
   localparam int SD = 20;
   localparam int LD = 30;
   logic core_clk, sys_rst, ext_reset_n, power_on_reset, brownout_detector, wake_irq, sleep_req;
   logic [3:0] clock_source_select;
   logic [1:0] startup_time_select, sleep_mode;
   logic osc_enable, lf_osc_select, async_timer_enable, core_clk_enable;
   logic core_reset, state_retain, startup_busy;
   logic [31:0] osc_ticks;
   int num_errors = 0;
   int cmp_count = 0;

   oscsd_sequencer #(.XTAL_WAKE_CYC(XW), .LF_WAKE_CYC(LW), .RESET_SHORT_DLY(SD),
      .RESET_LONG_DLY(LD)) uut (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clock_source_select(clock_source_select),
      .startup_time_select(startup_time_select),
      .ext_reset_n(ext_reset_n),
      .power_on_reset(power_on_reset),
      .brownout_detector(brownout_detector),
      .wake_irq(wake_irq),
      .sleep_req(sleep_req),
      .sleep_mode(sleep_mode),
      .osc_enable(osc_enable),
      .lf_osc_select(lf_osc_select),
      .async_timer_enable(async_timer_enable),
      .core_clk_enable(core_clk_enable),
      .core_reset(core_reset),
      .state_retain(state_retain),
      .startup_busy(startup_busy)
   );
   oscsd_xtal_model xtal (.core_clk(core_clk), .osc_enable(osc_enable), .osc_ticks(osc_ticks));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   initial
   begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
         num_errors++;
      end
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic wait_busy;
      int n;
      n = 0;
      while (startup_busy !== 1'b1 && n < 40)
      begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 40)
      begin
         num_errors++;
         results();
      end
   endtask

   // counts to release; a sleep request on the way must be ignored
   task automatic count_run(output int n);
      n = 0;
      while (core_clk_enable !== 1'b1 && n < 2000)
      begin
         @(posedge core_clk);
         sleep_req <= (n == 0);
         @(negedge core_clk);
         n++;
      end
      if (n >= 2000)
      begin
         num_errors++;
         results();
      end
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_start(input logic [3:0] src, input logic [1:0] sut, input int rsrc,
      input int w, input int e);
      int n;
      @(posedge core_clk);
      clock_source_select <= src;
      startup_time_select <= sut;
      ext_reset_n <= (rsrc != 0);
      power_on_reset <= (rsrc == 1);
      brownout_detector <= (rsrc == 2);
      repeat (6) @(posedge core_clk);
      ext_reset_n <= 1'b1;
      power_on_reset <= 1'b0;
      brownout_detector <= 1'b0;
      wait_busy();
      check("core_reset counting", core_reset, 1'b1);
      count_run(n);
      check("startup cycles", n, w + e);
      check("core_reset run", core_reset, 1'b0);
      check("lf_osc_select", lf_osc_select, src == SRC_LF_CRYSTAL);
      check("async_timer_enable run", async_timer_enable, 1'b1);
      $display("start test %0h/%0h done", src, sut);
   endtask

   task automatic t_sleep(input logic [1:0] m, input logic osc, input logic tmr, input int w);
      logic [31:0] t0;
      int n;
      @(posedge core_clk);
      sleep_mode <= m;
      sleep_req <= 1'b1;
      @(posedge core_clk);
      sleep_req <= 1'b0;
      repeat (2) @(negedge core_clk);
      check("core_clk_enable sleep", core_clk_enable, 1'b0);
      check("state_retain", state_retain, 1'b1);
      check("osc_enable", osc_enable, osc);
      check("async_timer_enable", async_timer_enable, tmr);
      t0 = osc_ticks;
      repeat (10) @(negedge core_clk);
      check("osc ticks", osc_ticks - t0, osc ? 10 : 0);
      @(posedge core_clk);
      wake_irq <= 1'b1;
      wait_busy();
      check("core_reset wake", core_reset, 1'b0);
      check("state_retain wake", state_retain, 1'b1);
      count_run(n);
      check("wake cycles", n, w);
      check("core_reset after wake", core_reset, 1'b0);
      @(posedge core_clk);
      wake_irq <= 1'b0;
      repeat (6) @(posedge core_clk);
      $display("sleep test mode %0d done", m);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      sys_rst = 1'b1;
      ext_reset_n = 1'b1;
      power_on_reset = 1'b0;
      brownout_detector = 1'b0;
      wake_irq = 1'b0;
      sleep_req = 1'b0;
      sleep_mode = SLP_POWER_DOWN;
      clock_source_select = 4'hA;
      startup_time_select = SUT_00;
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_start(SRC_LF_CRYSTAL, SUT_00, 0, 1024, SD);
      t_start(SRC_LF_CRYSTAL, SUT_01, 1, 1024, LD);
      t_start(SRC_LF_CRYSTAL, SUT_10, 2, LW, LD);
      t_start(SRC_LF_CRYSTAL, SUT_11, 0, LW, LD);
      t_start(4'hA, SUT_00, 1, 258, SD);
      t_start(4'hC, SUT_01, 2, 258, LD);
      t_start(4'hE, SUT_10, 0, 1024, 0);
      t_start(4'hA, SUT_11, 1, 1024, SD);
      t_start(4'hB, SUT_00, 2, 1024, LD);
      t_start(4'hD, SUT_01, 0, XW, 0);
      t_start(4'hF, SUT_10, 1, XW, SD);
      t_start(4'hB, SUT_11, 2, XW, LD);
      t_sleep(SLP_POWER_DOWN, 1'b0, 1'b0, XW);
      t_sleep(SLP_POWER_SAVE, 1'b0, 1'b1, XW);
      t_sleep(SLP_STANDBY, 1'b1, 1'b0, STANDBY_WAKE_CYC);
      t_sleep(2'h3, 1'b0, 1'b0, XW);
      results();
   end
endmodule
